// [src/dsp_ctl.sv]
// Chosen here: the APB interface to the registers and the register offsets.
`include "dsp_cfg.svh"
module dsp_ctl
	import dsp_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clk_en,
	input  wire logic psel,
	input  wire logic penable,
	input  wire logic pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	dsp_link_if.ctl          link
);
	localparam int REFI = `DSP_REFI_NS / `DSP_PCLK_NS;
	localparam int REFI_HOT = `DSP_REFI_HOT_NS / `DSP_PCLK_NS;
	typedef enum logic [2:0] {
		C_RUN   = 3'b000,
		C_ODTW  = 3'b001,
		C_ENTER = 3'b010,
		C_LOW   = 3'b011,
		C_EXIT  = 3'b100
	} dsp_cst_e;
	dsp_cst_e    st_q, st_d;
	logic [5:0]  ctrl_q, ctrl_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d, pslverr_q, pslverr_d;
	logic [3:0]  div_q, div_d;
	logic        ck_q, ck_d, ck_rise;
	logic        cke_q, cke_d, odt_q, odt_d;
	dsp_cmd_e    cmd_q, cmd_d;
	logic [7:0]  cnt_q, cnt_d;
	logic [8:0]  rdw_q, rdw_d;
	logic [15:0] refi_q, refi_d;
	logic        sr_q, sr_d, done_q, done_d;
	logic        hot_timer;
	logic [1:0]  hit;
	// apb decode shared by read and write
	function automatic logic [1:0] dec(input logic [11:0] a);
		dec = {a == `DSP_OFS_STAT, a == `DSP_OFS_CTRL};
	endfunction : dec
	assign ck_rise = ck_d & ~ck_q;
	assign hot_timer = (refi_q == 16'h0000);
	assign hit = dec(paddr);
	// apb slave, one wait state, orders and status
	always_comb begin
		ctrl_d = ctrl_q;
		prdata_d = prdata_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		if (st_q == C_EXIT && done_d && !done_q)
			ctrl_d[`DSP_CTRL_EXIT] = 1'b0; // hardware clears exit order
		// write lands on the edge that sees pready, a new order wins
		if (psel && penable && pready_q && pwrite && hit[0])
			ctrl_d = pwdata[5:0];
		if (psel && penable && !pready_q) begin
			pready_d = 1'b1;
			pslverr_d = (hit == 2'b00);
			prdata_d = 32'h0000_0000;
			if (!pwrite && hit[0])
				prdata_d = {26'h000_0000, ctrl_q};
			if (!pwrite && hit[1])
				prdata_d = {24'h00_0000, rdw_q == 9'h000, done_q,
					st_q == C_LOW, cke_q, odt_q, st_q};
		end
	end
	// link sequencer, moves on memory clock rising edges
	always_comb begin
		div_d = div_q + 4'h1;
		ck_d = ck_q;
		if (div_q == `DSP_CK_HALF - 4'h1) begin
			div_d = 4'h0;
			ck_d = ~ck_q;
		end
		st_d = st_q;
		cke_d = cke_q;
		odt_d = odt_q;
		cmd_d = cmd_q;
		cnt_d = cnt_q;
		rdw_d = rdw_q;
		sr_d = sr_q;
		done_d = done_q;
		refi_d = (refi_q == 16'h0000) ? 16'h0000 : refi_q - 16'h0001;
		// a hot case shortens a running interval at once
		if (ctrl_q[`DSP_CTRL_HOT] && refi_q > 16'(REFI_HOT))
			refi_d = 16'(REFI_HOT);
		if (ck_rise) begin
			cmd_d = DSP_CMD_NOP;
			if (cnt_q != 8'h00)
				cnt_d = cnt_q - 8'h01;
			if (rdw_q != 9'h000 && cke_q)
				rdw_d = rdw_q - 9'h001;
			unique case (st_q)
			C_RUN: begin
				// termination only once the read window is open
				odt_d = (rdw_q == 9'h000);
				if (hot_timer) begin
					// a due refresh goes first, so no power-down skips it
					cmd_d = DSP_CMD_REF;
					refi_d = ctrl_q[`DSP_CTRL_HOT] ? 16'(REFI_HOT)
						: 16'(REFI);
					cnt_d = 8'h01;
				end else if (ctrl_q[`DSP_CTRL_SR] && !ctrl_q[`DSP_CTRL_ROW]
					&& cnt_q == 8'h00) begin
					odt_d = 1'b0;
					st_d = C_ODTW;
					sr_d = 1'b1;
					cnt_d = `DSP_CKE_MIN;
				end else if (ctrl_q[`DSP_CTRL_PD] && cnt_q == 8'h00
					&& rdw_q == 9'h000) begin
					st_d = C_ENTER;
					sr_d = 1'b0;
				end
			end
			C_ODTW: if (cnt_q == 8'h00) st_d = C_ENTER;
			C_ENTER: begin
				cke_d = 1'b0;
				if (sr_q)
					cmd_d = DSP_CMD_REF;
				cnt_d = `DSP_CKE_MIN;
				done_d = 1'b0;
				st_d = C_LOW;
			end
			C_LOW: begin
				// power-down ends at the refresh deadline or on an exit order, self refresh on an exit order only
				if (cnt_q == 8'h00 && (ctrl_q[`DSP_CTRL_EXIT]
					|| (!sr_q && hot_timer))) begin
					cke_d = 1'b1;
					st_d = C_EXIT;
					if (sr_q) begin
						cnt_d = `DSP_XSNR;
						rdw_d = 9'(`DSP_XSRD);
					end else begin
						cnt_d = `DSP_XP;
						rdw_d = ctrl_q[`DSP_CTRL_SLOW] ? 9'(`DSP_XARDS)
							: 9'(`DSP_XARD);
					end
				end
			end
			C_EXIT: if (cnt_q == 8'h00) begin
				// dll assumed locked, no reset issued
				if (sr_q)
					refi_d = 16'(REFI);
				done_d = 1'b1;
				st_d = C_RUN;
				cnt_d = `DSP_CKE_MIN;
			end
			default: st_d = C_RUN;
			endcase
		end
	end
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= C_RUN;
			ctrl_q <= 6'h00;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			div_q <= 4'h0;
			ck_q <= 1'b0;
			cke_q <= 1'b1;
			odt_q <= 1'b0;
			cmd_q <= DSP_CMD_NOP;
			cnt_q <= `DSP_CKE_MIN;
			rdw_q <= 9'h000;
			refi_q <= 16'h0000;
			sr_q <= 1'b0;
			done_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			ctrl_q <= ctrl_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			div_q <= div_d;
			ck_q <= ck_d;
			cke_q <= cke_d;
			odt_q <= odt_d;
			cmd_q <= cmd_d;
			cnt_q <= cnt_d;
			rdw_q <= rdw_d;
			refi_q <= refi_d;
			sr_q <= sr_d;
			done_q <= done_d;
		end
	end
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign link.ck = ck_q;
	assign link.cke = cke_q;
	assign link.odt = odt_q;
	assign link.cmd = cmd_q;
endmodule : dsp_ctl

// [include/dsp_cfg.svh]
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH
// link clock divider: memory clock period in pclk cycles (half period)
`define DSP_CK_HALF        4'h4
// minimum cke registrations on the memory clock
`define DSP_CKE_MIN        8'h03
// self refresh exit to non-read (memory clocks)
`define DSP_XSNR           8'h0a
// self refresh exit to read (memory clocks)
`define DSP_XSRD           8'hc8
// power-down exit to non-read, fast and slow read exit
`define DSP_XP             8'h02
`define DSP_XARD           8'h02
`define DSP_XARDS          8'h07
// write recovery and write-to-read minimum
`define DSP_WR             8'h03
`define DSP_WTR_MIN        8'h02
// mode register set delay
`define DSP_MRD            8'h02
// read burst incl. postamble, write burst incl. postamble
`define DSP_RD_BURST       8'h05
`define DSP_WR_BURST       8'h04
// refresh interval in ns and derived pclk count at 40 MHz
`define DSP_REFI_NS        7812
`define DSP_REFI_HOT_NS    3900
`define DSP_PCLK_NS        25
// apb register offsets of the controller
`define DSP_OFS_CTRL       12'h000
`define DSP_OFS_STAT       12'h004
// ctrl field positions
`define DSP_CTRL_SR        0
`define DSP_CTRL_PD        1
`define DSP_CTRL_EXIT      2
`define DSP_CTRL_SLOW      3
`define DSP_CTRL_HOT       4
`define DSP_CTRL_ROW       5
`endif

// [include/dsp_pkg.sv]
package dsp_pkg;
	typedef enum logic [2:0] {
		DSP_CMD_NOP = 3'b000,
		DSP_CMD_REF = 3'b001,
		DSP_CMD_ACT = 3'b010,
		DSP_CMD_PRE = 3'b011,
		DSP_CMD_RD  = 3'b100,
		DSP_CMD_WR  = 3'b101,
		DSP_CMD_LMR = 3'b110
	} dsp_cmd_e;
	typedef enum logic [1:0] {
		DSP_ST_ACTIVE = 2'b00,
		DSP_ST_PPD    = 2'b01,
		DSP_ST_APD    = 2'b10,
		DSP_ST_SREF   = 2'b11
	} dsp_mode_e;
endpackage : dsp_pkg

// [include/dsp_link_if.sv]
interface dsp_link_if;
	import dsp_pkg::*;
	logic     ck;    // memory clock from controller
	logic     cke;   // clock enable
	logic     odt;   // termination control
	dsp_cmd_e cmd;   // command code (nop also stands for deselect)
	dsp_mode_e mode; // device low-power state, for observation
	logic     rd_ok; // device ready for read after exit
	modport ctl (output ck, output cke, output odt, output cmd,
		input mode, input rd_ok);
	modport dev (input ck, input cke, input odt, input cmd,
		output mode, output rd_ok);
endinterface : dsp_link_if

// [src/dsp_dev.sv]
`include "dsp_cfg.svh"
// device end: tracks cke truth table on sampled memory clock edges
module dsp_dev
	import dsp_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clk_en,
	input  wire logic row_open,
	output logic      buf_on,
	output logic      dll_frozen,
	output logic      refreshing,
	dsp_link_if.dev   link
);
	dsp_mode_e  mode_q, mode_d;
	logic [2:0] ck_s_q, ck_s_d;
	logic [1:0] cke_s_q, cke_s_d;
	dsp_cmd_e   cmd_s_q, cmd_s_d;
	dsp_cmd_e   cmd_q, cmd_d;
	logic       rdok_q, rdok_d;
	logic       cke_prev_q, cke_prev_d;
	logic [7:0] xs_q, xs_d;
	logic       buf_q, buf_d, dll_q, dll_d, ref_q, ref_d;
	logic       edge_r;
	assign edge_r = ck_s_q[1] & ~ck_s_q[2];
	// state from previous and current cke at each rising memory clock
	always_comb begin
		ck_s_d = {ck_s_q[1:0], link.ck};
		cke_s_d = {cke_s_q[0], link.cke};
		cmd_s_d = link.cmd;
		cmd_d = cmd_s_q; // second stage, in step with cke
		mode_d = mode_q;
		cke_prev_d = cke_prev_q;
		xs_d = xs_q;
		buf_d = buf_q;
		dll_d = dll_q;
		ref_d = (mode_q == DSP_ST_SREF); // level while self refreshing
		if (edge_r) begin
			cke_prev_d = cke_s_q[1];
			if (xs_q != 8'h00)
				xs_d = xs_q - 8'h01;
			if (cke_prev_q && !cke_s_q[1] && cmd_q == DSP_CMD_REF
				&& !row_open)
				mode_d = DSP_ST_SREF;
			else if (cke_prev_q && !cke_s_q[1] && cmd_q == DSP_CMD_NOP)
				mode_d = row_open ? DSP_ST_APD : DSP_ST_PPD;
			else if (!cke_prev_q && cke_s_q[1]
				&& cmd_q == DSP_CMD_NOP) begin
				if (mode_q == DSP_ST_SREF)
					xs_d = `DSP_XSRD;
				mode_d = DSP_ST_ACTIVE;
			end
			buf_d = (mode_d == DSP_ST_ACTIVE);
			dll_d = (mode_d == DSP_ST_PPD) || (mode_d == DSP_ST_SREF);
			ref_d = (mode_d == DSP_ST_SREF) || (cke_s_q[1]
				&& cmd_q == DSP_CMD_REF);
		end
		rdok_d = (xs_d == 8'h00) && (mode_d == DSP_ST_ACTIVE);
	end
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= DSP_ST_ACTIVE;
			ck_s_q <= 3'h0;
			cke_s_q <= 2'h3;
			cmd_s_q <= DSP_CMD_NOP;
			cmd_q <= DSP_CMD_NOP;
			rdok_q <= 1'b1;
			cke_prev_q <= 1'b1;
			xs_q <= 8'h00;
			buf_q <= 1'b1;
			dll_q <= 1'b0;
			ref_q <= 1'b0;
		end else if (clk_en) begin
			mode_q <= mode_d;
			ck_s_q <= ck_s_d;
			cke_s_q <= cke_s_d;
			cmd_s_q <= cmd_s_d;
			cmd_q <= cmd_d;
			rdok_q <= rdok_d;
			cke_prev_q <= cke_prev_d;
			xs_q <= xs_d;
			buf_q <= buf_d;
			dll_q <= dll_d;
			ref_q <= ref_d;
		end
	end
	assign buf_on = buf_q;
	assign dll_frozen = dll_q;
	assign refreshing = ref_q;
	assign link.mode = mode_q;
	assign link.rd_ok = rdok_q;
endmodule : dsp_dev

// [bench/dsp_link_props.sv]
module dsp_link_props
	import dsp_pkg::*;
(
	input wire logic      pclk,
	input wire logic      presetn,
	input wire logic      ck,
	input wire logic      cke,
	input wire logic      odt,
	input wire dsp_cmd_e  cmd,
	input wire dsp_mode_e mode,
	input wire logic      rd_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       ck_q;
	logic       cke_q;
	logic [1:0] rises_q;
	// memory clock rises seen since cke last moved
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_q    <= 1'b0;
			cke_q   <= 1'b1;
			rises_q <= 2'd0;
		end else begin
			ck_q  <= ck;
			cke_q <= cke;
			if (cke != cke_q)
				rises_q <= 2'd0;
			else if (ck && !ck_q && rises_q != 2'd3)
				rises_q <= rises_q + 2'd1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// link protocol checks
	a_cke_hold: assert property ($changed(cke) |-> rises_q == 2'd3)
		else $error("cke moved before three registrations");
	a_exit_nop: assert property ($rose(cke) |-> cmd == DSP_CMD_NOP)
		else $error("command other than nop on exit edge");
	a_entry_cmd: assert property ($fell(cke) |->
		cmd inside {DSP_CMD_NOP, DSP_CMD_REF})
		else $error("illegal command on entry edge");
	a_sref_odt_off: assert property ($fell(cke) && cmd == DSP_CMD_REF
		|-> !odt) else $error("termination on at self refresh entry");
	a_sref_entry: assert property ($fell(cke) && cmd == DSP_CMD_REF
		|-> ##[1:24] mode == DSP_ST_SREF) else $error("no self refresh");
	a_pd_entry: assert property ($fell(cke) && cmd == DSP_CMD_NOP
		|-> ##[1:24] mode inside {DSP_ST_PPD, DSP_ST_APD})
		else $error("no power-down entry");
	a_exit_mode: assert property ($rose(cke)
		|-> ##[1:24] mode == DSP_ST_ACTIVE) else $error("no exit");
	a_ck_running: assert property ($changed(ck) |-> ##4 $changed(ck))
		else $error("memory clock not steady");
	a_sref_odt_low: assert property (mode == DSP_ST_SREF |-> !odt)
		else $error("termination on in self refresh");
	a_read_window: assert property (cmd == DSP_CMD_RD |-> rd_ok)
		else $error("read before read window");
	a_odt_exit_low: assert property (mode == DSP_ST_ACTIVE && !rd_ok
		|-> !odt) else $error("termination on before read window");
	// main scenarios
	c_sref: cover property ($fell(cke) && cmd == DSP_CMD_REF);
	c_ppd: cover property (mode == DSP_ST_PPD);
	c_apd: cover property (mode == DSP_ST_APD);
endmodule : dsp_link_props

// [bench/dram_self_refresh_power_down_test.sv]
`include "dsp_cfg.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
	miscompares++; $display("wrong value at %0t: got %h want %h", \
	$time, a, b); end end
module dram_self_refresh_power_down_test
	import dsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready;
	logic        pslverr, row_open, buf_on, dll_frozen, refreshing, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        row, hot;
	int          miscompares, total_checks, n;
	dsp_link_if link_w();
	dsp_ctl i_dsp_ctl (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link_w.ctl));
	dsp_dev i_dsp_dev (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.row_open(row_open), .buf_on(buf_on), .dll_frozen(dll_frozen),
		.refreshing(refreshing), .link(link_w.dev));
	dsp_link_props i_dsp_link_props (.pclk(pclk), .presetn(presetn),
		.ck(link_w.ck), .cke(link_w.cke), .odt(link_w.odt),
		.cmd(link_w.cmd), .mode(link_w.mode), .rd_ok(link_w.rd_ok));
	// clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// bounded wait for a device state
	task automatic wait_mode(input dsp_mode_e m, input int lim);
		int k;
		k = 0;
		while (link_w.mode !== m && k < lim) begin
			@(posedge pclk);
			k++;
		end
	endtask : wait_mode
	// expected power-down kind
	function automatic dsp_mode_e pd_mode(input logic r);
		return r ? DSP_ST_APD : DSP_ST_PPD;
	endfunction : pd_mode
	// refresh deadline in pclk cycles
	function automatic int refi(input logic h);
		return (h ? `DSP_REFI_HOT_NS : `DSP_REFI_NS) / `DSP_PCLK_NS;
	endfunction : refi
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	// watchdog
	initial begin
		repeat (30000) @(posedge pclk);
		miscompares++;
		end_of_test();
	end
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, row_open} = 5'b0;
		clk_en = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		void'($urandom(64023));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `DSP_OFS_STAT, 32'h0000_0000);
		`CHK(rdat[5:0], 6'h10)
		apb(1'b0, 12'h008, 32'h0000_0000);
		`CHK(rerr, 1'b1)
		$display("test registers done");
		apb(1'b1, `DSP_OFS_CTRL, 32'h0000_0001);
		wait_mode(DSP_ST_SREF, 400);
		`CHK({link_w.mode, link_w.odt, refreshing}, 4'hd)
		apb(1'b1, `DSP_OFS_CTRL, 32'h0000_0004);
		for (n = 0; n < 400 && link_w.cke !== 1'b1; n++) @(posedge pclk);
		for (n = 0; n < 10 * 8; n++) begin
			@(posedge pclk);
			`CHK(link_w.cmd, DSP_CMD_NOP)
		end
		`CHK({link_w.rd_ok, link_w.odt}, 2'b00)
		for (n = 80; n < 2000 && link_w.rd_ok !== 1'b1; n++) @(posedge pclk);
		`CHK(n >= 199 * 8 && n < 2000, 1'b1)
		apb(1'b1, `DSP_OFS_CTRL, 32'h0000_0000);
		$display("test self refresh done");
		for (int i = 0; i < 4; i++) begin
			row = 1'($urandom);
			hot = 1'($urandom);
			row_open <= row;
			apb(1'b1, `DSP_OFS_CTRL, {26'h0, row, hot, 1'($urandom), 3'h2});
			wait_mode(pd_mode(row), 400);
			`CHK(link_w.mode, pd_mode(row))
			`CHK({buf_on, dll_frozen}, {1'b0, !row})
			if (i[0])
				apb(1'b1, `DSP_OFS_CTRL, {26'h0, row, hot, 4'h6});
			wait_mode(DSP_ST_ACTIVE, refi(hot) + 64);
			`CHK(link_w.mode, DSP_ST_ACTIVE)
			`CHK(buf_on, 1'b1)
			apb(1'b1, `DSP_OFS_CTRL, 32'h0000_0000);
			repeat (64) @(posedge pclk);
		end
		$display("test power-down done");
		end_of_test();
	end
endmodule : dram_self_refresh_power_down_test
